// ==== core/dic_pkg.sv ====
// shared constants for the discrete input conditioner
package dic_pkg;

    // ****************************************
    // channel layout
    // ****************************************
    localparam int DIC_NUM_IN = 2;
    localparam int DIC_CNT_W  = 16;
    localparam int DIC_DLY_W  = 13;

    // ****************************************
    // timing
    // ****************************************
    localparam int DIC_CLK_PERIOD_NS = 5;
    localparam int DIC_DLY_STEP_NS   = 10000000;
    localparam int DIC_STEP_CYCLES   = DIC_DLY_STEP_NS / DIC_CLK_PERIOD_NS;
    localparam logic [DIC_DLY_W-1:0] DIC_DLY_MAX = 13'h1770;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [DIC_CNT_W-1:0] DIC_CNT_RST  = 16'h0000;
    localparam logic                 DIC_PIN_RST  = 1'b0;
    localparam logic                 DIC_PULS_RST = 1'b0;

endpackage : dic_pkg

// ==== core/dic_top.sv ====
// two-channel discrete input conditioner: sync, polarity, delay, counting, events
`timescale 1ns/1ps

// Contract
// R1: two independent inputs, each fully configurable
// R2: non-inverted: active edge rising, active high
// R3: inverted: active edge falling, active low
// R4: definite delay 0 to 60 s both ways
// R5: 16-bit cumulative active edge counter
// R6: conditioned state readable, one means active
// R7: indication request on active edge when enabled
// R8: active edge event only when enabled
// R9: inactive edge event only when enabled
// R10: conditioned state to matrices and user logic
// R11: counter wraps to zero; software may overwrite
// R12: glitch shorter than delay discarded, timing restarts
module dic_top #(
    parameter int TICK_CYCLES = dic_pkg::DIC_STEP_CYCLES
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // field contacts
    input  wire logic                          discrete_in_first,
    input  wire logic                          discrete_in_second,
    // per-channel settings
    input  wire logic [dic_pkg::DIC_NUM_IN-1:0] inv_cfg,
    input  wire logic [dic_pkg::DIC_NUM_IN-1:0] ind_en,
    input  wire logic [dic_pkg::DIC_NUM_IN-1:0] on_event_en,
    input  wire logic [dic_pkg::DIC_NUM_IN-1:0] off_event_en,
    input  wire logic [dic_pkg::DIC_DLY_W-1:0]  delay_set    [dic_pkg::DIC_NUM_IN],
    // counter overwrite
    input  wire logic [dic_pkg::DIC_NUM_IN-1:0] cnt_wr_en,
    input  wire logic [dic_pkg::DIC_CNT_W-1:0]  cnt_wr_data  [dic_pkg::DIC_NUM_IN],
    // state and counters
    output logic      [dic_pkg::DIC_NUM_IN-1:0] di_state,
    output logic      [dic_pkg::DIC_CNT_W-1:0]  edge_cnt     [dic_pkg::DIC_NUM_IN],
    // routing
    output logic      [dic_pkg::DIC_NUM_IN-1:0] out_matrix_sig,
    output logic      [dic_pkg::DIC_NUM_IN-1:0] block_matrix_sig,
    output logic      [dic_pkg::DIC_NUM_IN-1:0] user_logic_sig,
    // pulses
    output logic      [dic_pkg::DIC_NUM_IN-1:0] ind_req,
    output logic      [dic_pkg::DIC_NUM_IN-1:0] on_event,
    output logic      [dic_pkg::DIC_NUM_IN-1:0] off_event
);
    import dic_pkg::*;

    localparam int                SUB_W    = $clog2(TICK_CYCLES + 1);
    localparam logic [SUB_W-1:0]  SUB_LAST = SUB_W'(TICK_CYCLES - 1);
    localparam logic [SUB_W-1:0]  SUB_ZERO = '0;
    localparam logic [DIC_DLY_W-1:0] HUN_ZERO = '0;

    // ****************************************
    // helpers
    // ****************************************
    // settings above the top of range act as the top of range
    function automatic logic [DIC_DLY_W-1:0] dic_clamp(input logic [DIC_DLY_W-1:0] d);
        dic_clamp = (d > DIC_DLY_MAX) ? DIC_DLY_MAX : d;
    endfunction : dic_clamp

    // ****************************************
    // input synchroniser
    // ****************************************
    logic [DIC_NUM_IN-1:0] sync1_reg;
    logic [DIC_NUM_IN-1:0] sync2_reg;
    logic [DIC_NUM_IN-1:0] sync1_next;
    logic [DIC_NUM_IN-1:0] sync2_next;

    always_comb begin
        sync1_next = {discrete_in_second, discrete_in_first}; // see R1
        sync2_next = sync1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= {DIC_NUM_IN{DIC_PIN_RST}};
            sync2_reg <= {DIC_NUM_IN{DIC_PIN_RST}};
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // ****************************************
    // definite delay
    // ****************************************
    // raw level held in stable_reg, still in pin polarity
    logic [DIC_NUM_IN-1:0] stable_reg;
    logic [DIC_NUM_IN-1:0] stable_next;
    logic [SUB_W-1:0]      sub_reg  [DIC_NUM_IN];
    logic [SUB_W-1:0]      sub_next [DIC_NUM_IN];
    logic [DIC_DLY_W-1:0]  hun_reg  [DIC_NUM_IN];
    logic [DIC_DLY_W-1:0]  hun_next [DIC_NUM_IN];

    always_comb begin
        for (int i = 0; i < DIC_NUM_IN; i++) begin
            stable_next[i] = stable_reg[i];
            sub_next[i]    = sub_reg[i];
            hun_next[i]    = hun_reg[i];
            if (sync2_reg[i] == stable_reg[i]) begin
                // a change that fell back before expiry is forgotten
                sub_next[i] = SUB_ZERO; // see R12
                hun_next[i] = HUN_ZERO; // see R12
            end else if (hun_reg[i] >= dic_clamp(delay_set[i])) begin
                stable_next[i] = sync2_reg[i]; // see R4
                sub_next[i]    = SUB_ZERO;
                hun_next[i]    = HUN_ZERO;
            end else if (sub_reg[i] == SUB_LAST) begin
                sub_next[i] = SUB_ZERO;
                hun_next[i] = hun_reg[i] + 13'h0001; // see R4
            end else begin
                sub_next[i] = sub_reg[i] + SUB_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stable_reg <= {DIC_NUM_IN{DIC_PIN_RST}};
            for (int i = 0; i < DIC_NUM_IN; i++) begin
                sub_reg[i] <= SUB_ZERO;
                hun_reg[i] <= HUN_ZERO;
            end
        end else begin
            stable_reg <= stable_next;
            for (int i = 0; i < DIC_NUM_IN; i++) begin
                sub_reg[i] <= sub_next[i];
                hun_reg[i] <= hun_next[i];
            end
        end
    end

    // ****************************************
    // polarity, edges, counter, pulses
    // ****************************************
    logic [DIC_NUM_IN-1:0] act_reg;
    logic [DIC_NUM_IN-1:0] act_next;
    logic [DIC_NUM_IN-1:0] ind_reg;
    logic [DIC_NUM_IN-1:0] ind_next;
    logic [DIC_NUM_IN-1:0] onev_reg;
    logic [DIC_NUM_IN-1:0] onev_next;
    logic [DIC_NUM_IN-1:0] offev_reg;
    logic [DIC_NUM_IN-1:0] offev_next;
    logic [DIC_CNT_W-1:0]  cnt_reg  [DIC_NUM_IN];
    logic [DIC_CNT_W-1:0]  cnt_next [DIC_NUM_IN];
    logic [DIC_NUM_IN-1:0] rise;
    logic [DIC_NUM_IN-1:0] fall;

    always_comb begin
        for (int i = 0; i < DIC_NUM_IN; i++) begin
            // flipping the polarity setting itself may produce an edge
            act_next[i]   = stable_next[i] ^ inv_cfg[i]; // see R2 see R3
            rise[i]       = act_next[i] & ~act_reg[i];
            fall[i]       = ~act_next[i] & act_reg[i];
            ind_next[i]   = rise[i] & ind_en[i];         // see R7
            onev_next[i]  = rise[i] & on_event_en[i];    // see R8
            offev_next[i] = fall[i] & off_event_en[i];   // see R9
            // a software write beats a coincident edge
            if (cnt_wr_en[i]) begin
                cnt_next[i] = cnt_wr_data[i]; // see R11
            end else if (rise[i]) begin
                cnt_next[i] = cnt_reg[i] + 16'h0001; // see R5 see R11
            end else begin
                cnt_next[i] = cnt_reg[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            act_reg   <= {DIC_NUM_IN{DIC_PULS_RST}};
            ind_reg   <= {DIC_NUM_IN{DIC_PULS_RST}};
            onev_reg  <= {DIC_NUM_IN{DIC_PULS_RST}};
            offev_reg <= {DIC_NUM_IN{DIC_PULS_RST}};
            for (int i = 0; i < DIC_NUM_IN; i++) begin
                cnt_reg[i] <= DIC_CNT_RST;
            end
        end else begin
            act_reg   <= act_next;
            ind_reg   <= ind_next;
            onev_reg  <= onev_next;
            offev_reg <= offev_next;
            for (int i = 0; i < DIC_NUM_IN; i++) begin
                cnt_reg[i] <= cnt_next[i];
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        di_state         = act_reg; // see R6
        out_matrix_sig   = act_reg; // see R10
        block_matrix_sig = act_reg; // see R10
        user_logic_sig   = act_reg; // see R10
        ind_req          = ind_reg;
        on_event         = onev_reg;
        off_event        = offev_reg;
        for (int i = 0; i < DIC_NUM_IN; i++) begin
            edge_cnt[i] = cnt_reg[i];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    for (genvar g = 0; g < DIC_NUM_IN; g++) begin : g_chk
        a_polarity_follow: assert property ( // see R2 see R3
            @(posedge clk) disable iff (rst)
            (stable_reg[g] == sync2_reg[g]) ##1 !rst
            |-> act_reg[g] == ($past(stable_next[g]) ^ $past(inv_cfg[g])))
            else $error("conditioned state does not match level and polarity");

        a_zero_delay: assert property ( // see R4
            @(posedge clk) disable iff (rst)
            (sync2_reg[g] != stable_reg[g]) && (delay_set[g] == 13'h0000)
            |=> stable_reg[g] == $past(sync2_reg[g]))
            else $error("zero delay did not pass change at once");

        a_no_early: assert property ( // see R4
            @(posedge clk) disable iff (rst)
            (sync2_reg[g] != stable_reg[g]) && (hun_reg[g] < dic_clamp(delay_set[g]))
            |=> stable_reg[g] == $past(stable_reg[g]))
            else $error("state changed before delay expired");

        a_glitch_drop: assert property ( // see R12
            @(posedge clk) disable iff (rst)
            (sync2_reg[g] == stable_reg[g])
            |=> (hun_reg[g] == 13'h0000) && (sub_reg[g] == SUB_ZERO))
            else $error("timer not restarted after change fell back");

        a_count_step: assert property ( // see R5
            @(posedge clk) disable iff (rst)
            $rose(act_reg[g]) && !$past(cnt_wr_en[g])
            |-> cnt_reg[g] == DIC_CNT_W'($past(cnt_reg[g]) + 16'h0001))
            else $error("counter did not step on active edge");

        a_count_wrap: assert property ( // see R11
            @(posedge clk) disable iff (rst)
            rise[g] && !cnt_wr_en[g] && (cnt_reg[g] == 16'hffff)
            |=> cnt_reg[g] == 16'h0000)
            else $error("counter did not wrap to zero");

        a_count_write: assert property ( // see R11
            @(posedge clk) disable iff (rst)
            cnt_wr_en[g] |=> cnt_reg[g] == $past(cnt_wr_data[g]))
            else $error("counter overwrite lost");

        a_ind_pulse: assert property ( // see R7
            @(posedge clk) disable iff (rst)
            ind_reg[g] == ($rose(act_reg[g]) && $past(ind_en[g])))
            else $error("indication request wrong");

        a_on_event: assert property ( // see R8
            @(posedge clk) disable iff (rst)
            onev_reg[g] == ($rose(act_reg[g]) && $past(on_event_en[g])))
            else $error("active edge event wrong");

        a_off_event: assert property ( // see R9
            @(posedge clk) disable iff (rst)
            offev_reg[g] == ($fell(act_reg[g]) && $past(off_event_en[g])))
            else $error("inactive edge event wrong");

        // the count must stand still unless an edge or a write moves it
        a_count_hold: assert property ( // see R5
            @(posedge clk) disable iff (rst)
            !rise[g] && !cnt_wr_en[g] |=> cnt_reg[g] == $past(cnt_reg[g]))
            else $error("counter moved without edge or write");

        a_delay_hold: assert property ( // see R4
            @(posedge clk) disable iff (rst)
            $changed(stable_reg[g])
            |-> $past(hun_reg[g] >= dic_clamp(delay_set[g])))
            else $error("level taken before delay expired");

        a_route_copy: assert property ( // see R10
            @(posedge clk) disable iff (rst)
            (out_matrix_sig[g] == di_state[g]) && (block_matrix_sig[g] == di_state[g])
            && (user_logic_sig[g] == di_state[g]))
            else $error("routing copies differ from state");

        a_ind_quiet: assert property ( // see R7
            @(posedge clk) disable iff (rst)
            !$past(ind_en[g]) |-> !ind_req[g])
            else $error("indication requested while disabled");

        // an edge cannot be active and inactive at once
        a_event_excl: assert property ( // see R8 see R9
            @(posedge clk) disable iff (rst)
            !(on_event[g] && off_event[g]))
            else $error("both edge events at once");

        a_pulse_single: assert property ( // see R8
            @(posedge clk) disable iff (rst)
            on_event[g] |=> !on_event[g])
            else $error("active edge event longer than one cycle");
    end

endmodule : dic_top

// ==== bench/dic_contacts.sv ====
// field contact model: two switch contacts fed by an external control voltage
`timescale 1ns/1ps
module dic_contacts (
    // clock
    input  wire logic       clk,
    // commanded contact levels
    input  wire logic [1:0] level_cmd,
    // contact outputs
    output logic            contact_first,
    output logic            contact_second
);
    // contacts start open, so the pins read low before any command
    initial begin
        contact_first  = 1'b0;
        contact_second = 1'b0;
    end
    // ****************************************
    // contact drive, one edge behind the command
    // ****************************************
    always @(posedge clk) begin
        contact_first  <= level_cmd[0];
        contact_second <= level_cmd[1];
    end
endmodule : dic_contacts

// ==== bench/test_discrete_input_conditioner.sv ====
// self-checking bench for the discrete input conditioner
`timescale 1ns/1ps
module test_discrete_input_conditioner;
    import dic_pkg::*;
    // short tick keeps the delay runs brief
    localparam int TICK = 4;
    logic                 clk = 1'b0, rst = 1'b1, pin0, pin1;
    logic [1:0]           pin_cmd = 2'h0, inv_cfg = 2'h0, ind_en = 2'h3, cnt_wr_en = 2'h0;
    logic [1:0]           on_event_en = 2'h3, off_event_en = 2'h3;
    logic [1:0]           di_state, out_m, blk_m, usr_m, ind_req, on_event, off_event;
    logic [DIC_DLY_W-1:0] delay_set   [DIC_NUM_IN];
    logic [DIC_CNT_W-1:0] cnt_wr_data [DIC_NUM_IN];
    logic [DIC_CNT_W-1:0] edge_cnt    [DIC_NUM_IN];
    logic [15:0]          n_ind [2], n_on [2], n_off [2];
    int                   miscompares = 0, comparisons = 0;

    always #2.5 clk = ~clk;

    dic_contacts i_contacts (.clk(clk), .level_cmd(pin_cmd), .contact_first(pin0),
        .contact_second(pin1));
    dic_top #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .rst(rst), .discrete_in_first(pin0),
        .discrete_in_second(pin1), .inv_cfg(inv_cfg), .ind_en(ind_en),
        .on_event_en(on_event_en), .off_event_en(off_event_en), .delay_set(delay_set),
        .cnt_wr_en(cnt_wr_en), .cnt_wr_data(cnt_wr_data), .di_state(di_state),
        .edge_cnt(edge_cnt), .out_matrix_sig(out_m), .block_matrix_sig(blk_m),
        .user_logic_sig(usr_m), .ind_req(ind_req), .on_event(on_event), .off_event(off_event));

    // ****************************************
    // pulse tallies
    // ****************************************
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (ind_req[i] === 1'b1) n_ind[i] <= n_ind[i] + 16'h1;
            if (on_event[i] === 1'b1) n_on[i] <= n_on[i] + 16'h1;
            if (off_event[i] === 1'b1) n_off[i] <= n_off[i] + 16'h1;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic set_pin(input int ch, input logic v);
        @(posedge clk);
        pin_cmd[ch] <= v;
    endtask : set_pin

    task automatic wait_state(input int ch, input logic v, input int lim);
        int n;
        n = 0;
        while (di_state[ch] !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= lim) begin
            miscompares++;
            $display("[ERR] %0t state wait timed out", $time);
            final_report();
        end
        chk({out_m[ch], blk_m[ch], usr_m[ch]}, {3{v}}, "routing copies");
    endtask : wait_state

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    initial begin
        delay_set[0] = 13'h0000;
        delay_set[1] = 13'h0002;
        cnt_wr_data[0] = 16'h0000;
        cnt_wr_data[1] = 16'h0000;
        for (int i = 0; i < 2; i++) {n_ind[i], n_on[i], n_off[i]} = 48'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(di_state, 2'h0, "reset state");
        chk(edge_cnt[0] | edge_cnt[1], 16'h0, "reset counts");
        $display("test reset done");
        // zero delay, non-inverted, all enables on
        set_pin(0, 1'b1);
        wait_state(0, 1'b1, 6);
        settle();
        chk(edge_cnt[0], 16'h1, "count on edge");
        chk(n_ind[0], 16'h1, "indication");
        chk(n_on[0], 16'h1, "on event");
        set_pin(0, 1'b0);
        wait_state(0, 1'b0, 6);
        settle();
        chk(n_off[0], 16'h1, "off event");
        chk(edge_cnt[0], 16'h1, "no count off");
        $display("test polarity normal done");
        // glitch shorter than two ticks of delay is dropped
        set_pin(1, 1'b1);
        repeat (4) @(posedge clk);
        set_pin(1, 1'b0);
        repeat (30) @(posedge clk);
        #1;
        chk(di_state[1], 1'b0, "glitch dropped");
        set_pin(1, 1'b1);
        repeat (6) @(posedge clk);
        #1;
        chk(di_state[1], 1'b0, "still delayed");
        wait_state(1, 1'b1, 12);
        $display("test delay done");
        // inverted: pin high becomes inactive, falling pin is the active edge
        @(posedge clk);
        inv_cfg[1] <= 1'b1;
        wait_state(1, 1'b0, 20);
        settle();
        chk(n_off[1], 16'h1, "inverted off event");
        set_pin(1, 1'b0);
        wait_state(1, 1'b1, 20);
        settle();
        chk(edge_cnt[1], 16'h2, "inverted count");
        $display("test polarity inverted done");
        // enables off: edges counted, no pulses
        @(posedge clk);
        {ind_en[0], on_event_en[0], off_event_en[0]} <= 3'h0;
        set_pin(0, 1'b1);
        wait_state(0, 1'b1, 6);
        set_pin(0, 1'b0);
        wait_state(0, 1'b0, 6);
        settle();
        chk(n_ind[0], 16'h1, "indication off");
        chk(n_on[0], 16'h1, "on event off");
        chk(n_off[0], 16'h1, "off event off");
        chk(edge_cnt[0], 16'h2, "count enables off");
        $display("test enables done");
        // overwrite to the top value, then wrap
        @(posedge clk);
        cnt_wr_data[0] <= 16'hffff;
        cnt_wr_en[0] <= 1'b1;
        @(posedge clk);
        cnt_wr_en[0] <= 1'b0;
        #1;
        chk(edge_cnt[0], 16'hffff, "overwrite");
        set_pin(0, 1'b1);
        wait_state(0, 1'b1, 6);
        settle();
        chk(edge_cnt[0], 16'h0, "wrap");
        chk(edge_cnt[1], 16'h2, "other channel untouched");
        chk(n_on[1], 16'h2, "second channel on events");
        chk(n_ind[1], 16'h2, "second channel indications");
        chk(n_off[1], 16'h1, "second channel off events");
        $display("test counter done");
        final_report();
    end
endmodule : test_discrete_input_conditioner
